// ===== hw/standby_pkg.sv
package standby_pkg;

  // ----------------------------------------------------------------
  // Register map of the plain register port
  // ----------------------------------------------------------------
  localparam int          REG_ADDR_W      = 4;
  localparam logic [3:0]  OFS_CTRL        = 4'h0;
  localparam logic [3:0]  OFS_STATUS      = 4'h4;
  localparam int          CTRL_IRQ_EN_BIT = 0;
  localparam int          STAT_HALT_BIT   = 0;
  localparam int          STAT_STOP_BIT   = 1;
  localparam int          STAT_WARM_BIT   = 2;
  localparam int          STAT_MODE_LSB   = 3;
  localparam int          STAT_GRANT_BIT  = 5;
  localparam logic        IRQ_EN_RESET    = 1'b0;
  localparam logic [7:0]  RDATA_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Standby modes, coded as {mode_select_a, mode_select_b}
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_RUN                 = 2'h3;
  localparam logic [1:0]  core_and_clkout_off_mode = 2'h0;
  localparam logic [1:0]  core_off_clkout_on_mode  = 2'h1;
  localparam logic [1:0]  MODE_OSC_OFF             = 2'h2;
  localparam logic [1:0]  MODE_RESET               = MODE_RUN;

  // ----------------------------------------------------------------
  // Oscillator start-up delay: 2^14 + 2.5 clock periods
  // ----------------------------------------------------------------
  localparam int          WARM_POW          = 14;
  localparam int          WARM_HALF_PERIODS = 2 * (2 ** WARM_POW) + 5;
  localparam int          WARM_CYCLES       = (WARM_HALF_PERIODS + 1) / 2;
  localparam int          WARM_CNT_W        = 15;
  localparam logic [6:0]  REFRESH_RESET     = 7'h00;

  // ----------------------------------------------------------------
  // Machine cycle kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CYC_FETCH   = 3'h0,
    CYC_MEM_RD  = 3'h1,
    CYC_MEM_WR  = 3'h2,
    CYC_IO_RD   = 3'h3,
    CYC_IO_WR   = 3'h4,
    CYC_INT_ACK = 3'h5
  } cyc_kind_e;

  typedef enum logic [6:0] {
    SEQ_T1      = 7'h01,
    SEQ_T2      = 7'h02,
    SEQ_T3      = 7'h04,
    fourth_t_state = 7'h08,
    SEQ_GRANT   = 7'h10,
    SEQ_STOPPED = 7'h20,
    SEQ_WARM    = 7'h40
  } seq_e;

endpackage : standby_pkg

// ===== hw/halt_standby_clock_controller.sv
`timescale 1ns/1ps
module halt_standby_clock_controller
#(
  parameter int WARM_CYCLES_P = standby_pkg::WARM_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          mode_select_a,
  input  wire logic                          mode_select_b,
  input  wire logic                          irq_n,
  input  wire logic                          nmi_n,
  input  wire logic                          wait_n,
  input  wire logic                          bus_claim_n,
  input  standby_pkg::cyc_kind_e             cyc_kind,
  input  wire logic [15:0]                   cyc_addr,
  input  wire logic [7:0]                    cyc_wdata,
  input  wire logic                          instr_last,
  input  wire logic                          halt_opcode,
  input  wire logic [7:0]                    refresh_page,
  input  wire logic [7:0]                    data_in,
  input  wire logic [standby_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [7:0]                         reg_rdata,
  output logic [15:0]                        addr_out,
  output logic                               addr_oe_n,
  output logic [7:0]                         data_out,
  output logic                               data_oe_n,
  output logic                               memory_strobe_n,
  output logic                               io_strobe_n,
  output logic                               rd_n,
  output logic                               wr_n,
  output logic                               strobe_oe_n,
  output logic                               opcode_fetch_n,
  output logic                               bus_grant_n,
  output logic                               halt_n,
  output logic                               core_run,
  output logic                               clk_out_run,
  output logic                               osc_run,
  output logic                               cyc_done,
  output logic [7:0]                         rdata_out,
  output logic                               take_nmi,
  output logic                               take_irq
);

  import standby_pkg::*;

  localparam logic [WARM_CNT_W-1:0] WARM_LAST = WARM_CNT_W'(WARM_CYCLES_P - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seq_e                  seq;
  seq_e                  next_seq;
  cyc_kind_e             kind_q;
  cyc_kind_e             next_kind;
  logic [15:0]           addr_q;
  logic [1:0]            mode_q;
  logic                  halted;
  logic                  irq_enable_flag;
  logic                  nmi_q;
  logic                  nmi_pend;
  logic [6:0]            refresh_cnt;
  logic [WARM_CNT_W-1:0] warm_cnt;

  logic                  is_last;
  logic                  accept_nmi;
  logic                  accept_irq;
  logic                  enter_halt;
  logic                  next_halted;
  logic                  wake;
  logic                  mem_kind;
  logic                  early;
  logic                  late;

  // ----------------------------------------------------------------
  // Interrupt sampling and halt bookkeeping
  // ----------------------------------------------------------------
  // A halted machine runs NOPs, so every cycle closes an instruction
  assign is_last    = instr_last | halted;
  assign accept_nmi = (seq == fourth_t_state) && is_last && nmi_pend;
  assign accept_irq = (seq == fourth_t_state) && is_last && !nmi_pend && !irq_n && irq_enable_flag;
  assign enter_halt = (seq == SEQ_T3) && (kind_q == CYC_FETCH) && halt_opcode && !halted;
  assign wake       = nmi_pend | !nmi_n | !irq_n;

  assign next_halted = enter_halt || (halted && !(accept_nmi || accept_irq));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_seq = seq;
    case (seq)
      SEQ_T1: begin
        next_seq = SEQ_T2;
      end
      SEQ_T2: begin
        if (wait_n) begin
          next_seq = SEQ_T3;
        end
      end
      SEQ_T3: begin
        next_seq = fourth_t_state;
      end
      fourth_t_state: begin
        if (!bus_claim_n) begin
          next_seq = SEQ_GRANT;
        end else if (next_halted && mode_q != MODE_RUN) begin
          // Stopping after the fourth T state re-arms after each wake NOP
          next_seq = SEQ_STOPPED;
        end else begin
          next_seq = SEQ_T1;
        end
      end
      SEQ_GRANT: begin
        if (bus_claim_n) begin
          next_seq = SEQ_T1;
        end
      end
      SEQ_STOPPED: begin
        if (wake) begin
          next_seq = (mode_q == MODE_OSC_OFF) ? SEQ_WARM : SEQ_T1;
        end
      end
      SEQ_WARM: begin
        if (warm_cnt == WARM_LAST) begin
          next_seq = SEQ_T1;
        end
      end
      default: begin
        next_seq = SEQ_T1;
      end
    endcase
  end

  // New cycle request is latched on entry to T1; halted cycles are NOP fetches
  assign next_kind = (next_seq == SEQ_T1) ? (next_halted ? CYC_FETCH : cyc_kind) : kind_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seq <= SEQ_T1;
    end else begin
      seq <= next_seq;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      kind_q <= CYC_FETCH;
      addr_q <= 16'h0000;
    end else if (next_seq == SEQ_T1 && seq != SEQ_T1) begin
      kind_q <= next_kind;
      addr_q <= cyc_addr;
    end
  end

  // Start-up counter only ever runs from the stopped oscillator; reset clears it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      warm_cnt <= '0;
    end else if (seq == SEQ_WARM) begin
      warm_cnt <= warm_cnt + WARM_CNT_W'(1);
    end else begin
      warm_cnt <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      halted <= 1'b0;
      halt_n <= 1'b1;
    end else begin
      halted <= next_halted;
      halt_n <= !next_halted;
    end
  end

  // Mode is captured with the halt, so later pin changes do not matter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_q <= MODE_RESET;
    end else if (enter_halt) begin
      mode_q <= {mode_select_a, mode_select_b};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nmi_q    <= 1'b1;
      nmi_pend <= 1'b0;
    end else begin
      nmi_q <= nmi_n;
      if (nmi_q && !nmi_n) begin
        nmi_pend <= 1'b1;
      end else if (accept_nmi) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  // Software write beats the hardware clear on acceptance
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_enable_flag <= IRQ_EN_RESET;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      irq_enable_flag <= reg_wdata[CTRL_IRQ_EN_BIT];
    end else if (accept_irq) begin
      irq_enable_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      take_nmi <= 1'b0;
      take_irq <= 1'b0;
    end else begin
      take_nmi <= accept_nmi;
      take_irq <= accept_irq;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating
  // ----------------------------------------------------------------
  // The pad gates the oscillator itself with clk_out_run, so clock out
  // keeps oscillator frequency and phase and rests low when gated
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      core_run    <= 1'b1;
      clk_out_run <= 1'b1;
      osc_run     <= 1'b1;
    end else begin
      core_run    <= (next_seq != SEQ_STOPPED) && (next_seq != SEQ_WARM);
      clk_out_run <= !((next_seq == SEQ_STOPPED && mode_q != core_off_clkout_on_mode)
                       || next_seq == SEQ_WARM);
      osc_run     <= !(next_seq == SEQ_STOPPED && mode_q == MODE_OSC_OFF);
    end
  end

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  assign mem_kind = (next_kind == CYC_FETCH) || (next_kind == CYC_MEM_RD) || (next_kind == CYC_MEM_WR);
  assign early    = (next_seq == SEQ_T1) || (next_seq == SEQ_T2);
  assign late     = (next_seq == SEQ_T2) || (next_seq == SEQ_T3);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      memory_strobe_n <= 1'b1;
      io_strobe_n     <= 1'b1;
      rd_n            <= 1'b1;
      wr_n            <= 1'b1;
      opcode_fetch_n  <= 1'b1;
    end else begin
      memory_strobe_n <= !(mem_kind && (early || next_seq == SEQ_T3));
      io_strobe_n     <= !((next_kind == CYC_IO_RD || next_kind == CYC_IO_WR
                            || next_kind == CYC_INT_ACK) && late);
      rd_n            <= !(((next_kind == CYC_FETCH || next_kind == CYC_MEM_RD) && early)
                           || (next_kind == CYC_IO_RD && late));
      wr_n            <= !((next_kind == CYC_MEM_WR || next_kind == CYC_IO_WR) && late);
      opcode_fetch_n  <= !((next_kind == CYC_FETCH || next_kind == CYC_INT_ACK) && early);
    end
  end

  // Refresh address takes the back half of every fetch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_out <= 16'h0000;
    end else if (next_kind == CYC_FETCH && (next_seq == SEQ_T3 || next_seq == fourth_t_state)) begin
      addr_out <= {refresh_page, 1'b0, refresh_cnt};
    end else if (next_seq == SEQ_T1) begin
      addr_out <= cyc_addr;
    end else begin
      addr_out <= addr_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      refresh_cnt <= REFRESH_RESET;
    end else if (seq == fourth_t_state && kind_q == CYC_FETCH) begin
      refresh_cnt <= refresh_cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      if (next_seq == SEQ_T1 && seq != SEQ_T1) begin
        data_out <= cyc_wdata;
      end
      data_oe_n <= !((next_kind == CYC_MEM_WR || next_kind == CYC_IO_WR)
                     && (early || next_seq == SEQ_T3 || next_seq == fourth_t_state));
    end
  end

  // Bus goes high impedance first, grant follows one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_oe_n   <= 1'b0;
      strobe_oe_n <= 1'b0;
      bus_grant_n <= 1'b1;
    end else begin
      addr_oe_n   <= (next_seq == SEQ_GRANT);
      strobe_oe_n <= (next_seq == SEQ_GRANT);
      bus_grant_n <= !(seq == SEQ_GRANT && next_seq == SEQ_GRANT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_out <= 8'h00;
      cyc_done  <= 1'b0;
    end else begin
      if (seq == SEQ_T2 && wait_n) begin
        rdata_out <= data_in;
      end
      cyc_done <= (seq == fourth_t_state);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= RDATA_RESET;
    end else if (reg_rd && reg_addr == OFS_CTRL) begin
      reg_rdata <= {7'h00, irq_enable_flag};
    end else if (reg_rd && reg_addr == OFS_STATUS) begin
      reg_rdata <= {2'h0, (seq == SEQ_GRANT), mode_q, (seq == SEQ_WARM), (seq == SEQ_STOPPED), halted};
    end else begin
      reg_rdata <= RDATA_RESET;
    end
  end

endmodule : halt_standby_clock_controller

// ===== tb/standby_props.sv
`timescale 1ns/1ps
module standby_props #(
  parameter int WARM_CYCLES_P = 8
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  refresh_page,
  input wire logic [15:0] addr_out,
  input wire logic        addr_oe_n,
  input wire logic        data_oe_n,
  input wire logic        memory_strobe_n,
  input wire logic        io_strobe_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        strobe_oe_n,
  input wire logic        opcode_fetch_n,
  input wire logic        bus_grant_n,
  input wire logic        halt_n,
  input wire logic        core_run,
  input wire logic        clk_out_run,
  input wire logic        osc_run,
  input wire logic        take_nmi,
  input wire logic        take_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Start-up length seen after each oscillator stop
  // ----------------------------------------------------------------
  int   warm_cnt;
  logic warm_on;

  // Checking only after the oscillator was off keeps idle wake-ups out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      warm_cnt <= 0;
      warm_on  <= 1'b0;
    end else if (!osc_run) begin
      warm_cnt <= 0;
      warm_on  <= 1'b1;
    end else if (!core_run) begin
      warm_cnt <= warm_cnt + 1;
    end else begin
      warm_on <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_awake_all_on: assert property (halt_n |-> core_run && clk_out_run && osc_run) else $error("stopped while not halted");
  a_osc_off_quiet: assert property (!osc_run |-> !clk_out_run && !core_run) else $error("clock runs with osc off");
  a_fetch_pairs: assert property (!opcode_fetch_n |-> (!memory_strobe_n || !io_strobe_n) or ##1 !io_strobe_n)
    else $error("fetch indicator without strobe");
  a_write_drives: assert property (!wr_n |-> !data_oe_n) else $error("write strobe without data");
  a_grant_float: assert property (!bus_grant_n |-> addr_oe_n && strobe_oe_n && data_oe_n) else $error("grant on driven bus");
  a_float_first: assert property ($fell(bus_grant_n) |-> $past(addr_oe_n) && $past(strobe_oe_n)) else $error("grant early");
  a_read_memory: assert property (!rd_n && io_strobe_n |-> !memory_strobe_n) else $error("read without request");
  a_refresh_addr: assert property ($rose(opcode_fetch_n) && !memory_strobe_n
    |-> addr_out[15:8] == refresh_page && !addr_out[7]) else $error("refresh address wrong");
  a_warm_len: assert property (core_run && warm_on |-> warm_cnt == WARM_CYCLES_P) else $error("start-up length wrong");
  a_nmi_first: assert property (!(take_nmi && take_irq)) else $error("both interrupts taken");

  c_osc_off: cover property (!osc_run);
  c_grant: cover property ($fell(bus_grant_n));
  c_irq: cover property (take_irq);
endmodule : standby_props

bind halt_standby_clock_controller standby_props #(.WARM_CYCLES_P(WARM_CYCLES_P)) standby_props_inst (
  .clk_sys, .rst_n, .refresh_page, .addr_out, .addr_oe_n, .data_oe_n, .memory_strobe_n, .io_strobe_n, .rd_n, .wr_n,
  .strobe_oe_n, .opcode_fetch_n, .bus_grant_n, .halt_n, .core_run, .clk_out_run, .osc_run, .take_nmi, .take_irq
);

// ===== tb/bus_partner.sv
`timescale 1ns/1ps
module bus_partner #(
  parameter int WAIT_W = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        slow,
  input  wire logic [15:0] addr_out,
  input  wire logic [7:0]  data_out,
  input  wire logic        memory_strobe_n,
  input  wire logic        io_strobe_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        strobe_oe_n,
  input  wire logic        opcode_fetch_n,
  output logic             wait_n,
  output logic [7:0]       data_in,
  output logic [7:0]       wr_seen,
  output logic [7:0]       io_seen
);
  int   wcnt;
  logic armed;

  initial begin
    wait_n  = 1'b1;
    data_in = 8'h00;
    wr_seen = 8'h00;
    io_seen = 8'h00;
    wcnt    = 0;
    armed   = 1'b0;
  end

  // ----------------------------------------------------------------
  // Memory and port side
  // ----------------------------------------------------------------
  // Only plain reads are stretched, so fetch timing stays fixed
  always @(posedge clk_sys) begin
    if (!wait_n) begin
      if (wcnt == 0) wait_n <= 1'b1;
      else wcnt <= wcnt - 1;
    end else if (slow && !armed && !memory_strobe_n && !rd_n && opcode_fetch_n) begin
      wait_n <= 1'b0;
      wcnt   <= WAIT_W - 1;
      armed  <= 1'b1;
    end else if (rd_n) begin
      armed <= 1'b0;
    end
    // Released data bus shows a changing pattern, never the last value
    if (!rd_n && !strobe_oe_n) data_in <= addr_out[7:0] ^ 8'h5A;
    else data_in <= ~data_in;
    if (!wr_n && (!memory_strobe_n || !io_strobe_n)) wr_seen <= data_out;
    if (!io_strobe_n && opcode_fetch_n) io_seen <= addr_out[7:0];
  end
endmodule : bus_partner

// ===== tb/halt_standby_clock_controller_tb.sv
`timescale 1ns/1ps
module halt_standby_clock_controller_tb;
  import standby_pkg::*;
  localparam int WARM   = 8;
  localparam int WAIT_W = 3;
  logic        clk_sys, rst_n, mode_select_a, mode_select_b, irq_n, nmi_n, wait_n, bus_claim_n, slow, seen;
  cyc_kind_e   cyc_kind;
  logic [15:0] cyc_addr, addr_out;
  logic [7:0]  cyc_wdata, refresh_page, data_in, reg_wdata, reg_rdata, data_out, rdata_out, wr_seen, io_seen, rd_val;
  logic [3:0]  reg_addr;
  logic        instr_last, halt_opcode, reg_wr, reg_rd, addr_oe_n, data_oe_n, memory_strobe_n, io_strobe_n, rd_n, wr_n;
  logic        strobe_oe_n, opcode_fetch_n, bus_grant_n, halt_n, core_run, clk_out_run, osc_run, cyc_done, take_nmi, take_irq;
  int          n_errors, n_compared, lat0, lat1;

  halt_standby_clock_controller #(.WARM_CYCLES_P(WARM)) halt_standby_clock_controller_inst (
    .clk_sys, .rst_n, .mode_select_a, .mode_select_b, .irq_n, .nmi_n, .wait_n, .bus_claim_n, .cyc_kind, .cyc_addr,
    .cyc_wdata, .instr_last, .halt_opcode, .refresh_page, .data_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .addr_out, .addr_oe_n, .data_out, .data_oe_n, .memory_strobe_n, .io_strobe_n, .rd_n, .wr_n,
    .strobe_oe_n, .opcode_fetch_n, .bus_grant_n, .halt_n, .core_run, .clk_out_run, .osc_run, .cyc_done, .rdata_out,
    .take_nmi, .take_irq);
  bus_partner #(.WAIT_W(WAIT_W)) bus_partner_inst (
    .clk_sys, .slow, .addr_out, .data_out, .memory_strobe_n, .io_strobe_n, .rd_n, .wr_n, .strobe_oe_n,
    .opcode_fetch_n, .wait_n, .data_in, .wr_seen, .io_seen);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic wait_for(ref logic s, input logic v, input string what);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (s === v) return;
    end
    $display("BAD %s exp %b got timeout", what, v);
    n_errors++;
    finish_test();
  endtask : wait_for

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : reg_read

  // Cycle inputs are taken at a T1 entry, so one stale cycle passes first
  task automatic run_cyc(input cyc_kind_e k, input logic [15:0] a, input logic [7:0] d, output int lat);
    wait_for(cyc_done, 1'b1, "cyc_done");
    cyc_kind  <= k;
    cyc_addr  <= a;
    cyc_wdata <= d;
    wait_for(cyc_done, 1'b1, "cyc_done");
    cyc_kind <= CYC_FETCH;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (cyc_done !== 1'b1 && lat < 50);
    if (cyc_done !== 1'b1) begin
      $display("BAD cyc_done exp 1 got timeout");
      n_errors++;
      finish_test();
    end
  endtask : run_cyc

  task automatic halt_enter(input logic [1:0] m);
    {mode_select_a, mode_select_b} <= m;
    halt_opcode <= 1'b1;
    wait_for(halt_n, 1'b0, "halt_n");
    halt_opcode <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("run flags", {5'h00, m == 2'h3, m[0], m != 2'h2}, {5'h00, core_run, clk_out_run, osc_run});
  endtask : halt_enter

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    {rst_n, mode_select_a, mode_select_b, irq_n, nmi_n, bus_claim_n} = 6'h1F;
    {instr_last, halt_opcode, reg_wr, reg_rd, slow} = 5'h10;
    cyc_kind = CYC_FETCH;
    {cyc_addr, cyc_wdata, reg_addr, reg_wdata} = '0;
    refresh_page = 8'h3C;
    n_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk("reset outs", 8'h1F, {3'h0, core_run, clk_out_run, osc_run, halt_n, bus_grant_n});
    reg_read(OFS_CTRL, rd_val);
    chk("ctrl", {7'h00, IRQ_EN_RESET}, rd_val);
    reg_write(OFS_CTRL, 8'hFF);
    reg_read(OFS_CTRL, rd_val);
    chk("ctrl", 8'h01, rd_val);
    reg_write(4'h8, 8'hFF);
    reg_read(4'h8, rd_val);
    chk("unmapped", 8'h00, rd_val);
    reg_write(OFS_CTRL, 8'h00);
    reg_read(OFS_STATUS, rd_val);
    chk("status", 8'h00, rd_val & 8'h27);
    run_cyc(CYC_MEM_RD, 16'h1234, 8'h00, lat0);
    chk("rdata", 8'h34 ^ 8'h5A, rdata_out);
    slow <= 1'b1;
    run_cyc(CYC_MEM_RD, 16'h1299, 8'h00, lat1);
    chk("rdata slow", 8'h99 ^ 8'h5A, rdata_out);
    chk("wait stretch", 8'(WAIT_W), 8'(lat1 - lat0));
    slow <= 1'b0;
    run_cyc(CYC_MEM_WR, 16'h2000, 8'hC3, lat0);
    chk("write data", 8'hC3, wr_seen);
    run_cyc(CYC_IO_RD, 16'hAB56, 8'h00, lat0);
    chk("io addr", 8'h56, io_seen);
    run_cyc(CYC_IO_WR, 16'hCD77, 8'h5E, lat0);
    chk("io wr addr", 8'h77, io_seen);
    chk("io wr data", 8'h5E, wr_seen);
    run_cyc(CYC_INT_ACK, 16'h0000, 8'h00, lat0);
    bus_claim_n <= 1'b0;
    wait_for(bus_grant_n, 1'b0, "grant");
    chk("float", 8'h03, {6'h00, addr_oe_n, strobe_oe_n});
    bus_claim_n <= 1'b1;
    wait_for(bus_grant_n, 1'b1, "release");
    for (int m = 3; m >= 0; m--) begin
      halt_enter(2'(m));
      nmi_n <= 1'b0;
      @(posedge clk_sys);
      nmi_n <= 1'b1;
      wait_for(take_nmi, 1'b1, "take_nmi");
      @(posedge clk_sys);
      chk("halt_n", 8'h01, 8'(halt_n));
    end
    halt_enter(2'h0);
    irq_n <= 1'b0;
    wait_for(core_run, 1'b1, "wake");
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk_sys);
      seen = seen | take_irq;
    end
    chk("masked irq", 8'h00, 8'(seen));
    irq_n <= 1'b1;
    wait_for(core_run, 1'b0, "restop");
    chk("still halted", 8'h00, 8'(halt_n));
    reg_write(OFS_CTRL, 8'h01);
    irq_n <= 1'b0;
    wait_for(take_irq, 1'b1, "take_irq");
    irq_n <= 1'b1;
    reg_read(OFS_CTRL, rd_val);
    chk("ctrl cleared", 8'h00, rd_val);
    halt_enter(2'h2);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("reset wake", 8'h0F, {4'h0, core_run, clk_out_run, osc_run, halt_n});
    finish_test();
  end
endmodule : halt_standby_clock_controller_tb
